// ### aok_cfg.svh
`ifndef AOK_CFG_SVH
`define AOK_CFG_SVH
`define AOK_N_ALARM        6
`define AOK_N_VAR          8
`define AOK_VAL_W          16
// Register offsets (byte addresses).
`define AOK_OFS_CTRL       8'h00
`define AOK_OFS_STATUS     8'h04
`define AOK_OFS_INT_STAT   8'h08
`define AOK_OFS_INT_CLR    8'h0c
`define AOK_OFS_INT_EN     8'h10
`define AOK_OFS_CODE       8'h14
`define AOK_OFS_CODE_IN    8'h18
`define AOK_OFS_VAL_BASE   8'h20
`define AOK_OFS_ACFG_BASE  8'h40
`define AOK_OFS_ALO_BASE   8'h60
`define AOK_OFS_AHI_BASE   8'h80
`define AOK_OFS_AHYS_BASE  8'ha0
// CTRL field positions.
`define AOK_CTRL_VALID_BIT 0
`define AOK_CTRL_ANYST_BIT 1
`define AOK_CTRL_STXT_BIT  2
`define AOK_CTRL_KEYS_LSB  4
`define AOK_CTRL_LAST_LSB  8
// Reset values: keys Both, good data only, status text on, last input 7.
`define AOK_CTRL_RST       32'h0000_0724
`define AOK_CODE_RST       32'h3030_3030
// Blink half period: 250 ms at 125 MHz.
`define AOK_BLINK_MS       250
`define AOK_CLK_KHZ        125000
`define AOK_BLINK_CYC      (`AOK_BLINK_MS * `AOK_CLK_KHZ)
`endif

// ### aok_core.sv
`include "aok_cfg.svh"
`default_nettype none
// Operation
// - Six alarms, each picks one of eight variables as source.
// - Alarm acts as high, low, or combined high and low.
// - Polarity bit chooses open or closed contact when inactive.
// - Alarm outputs come only from local comparison, configuration and bus power.
// - Variable with active linked alarm blinks normal and inverted.
// - Global setting: trip on good status only, or regardless.
// - Variable with bad status is shown inverted, status field shown.
// - Low, high and hysteresis each have their own enable.
// - Quick access needs four-character code; code 0000 enters directly.
// - With status text on, screens 1 and 4 show Good or Bad.
// - Last input number limits operating-mode scrolling.
// - Button functions move to four external inputs; panel may be off.
// - Key source: internal, external, both, or internal plus port.
// - Key status muted in configuration menu except internal plus port.
// - Internal plus port: external inputs are discrete host inputs.
// - Program+enter opens configuration, program+up opens quick access.
module aok_core (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic [31:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        bus_power,
   input  wire logic [7:0]  var_good,
   input  wire logic [5:0]  panel_btn,
   input  wire logic [5:0]  ext_btn,
   input  wire logic        menu_exit,
   output logic      [5:0]  alarm_contact,
   output logic      [7:0]  var_invert,
   output logic      [7:0]  var_bad,
   output logic             status_text_on,
   output logic      [2:0]  screen_index,
   output logic      [5:0]  key_status,
   output logic      [5:0]  discrete_input_block,
   output logic      [1:0]  menu_mode,
   output logic             irq
);
   aok_pkg::aok_state_t s_q;
   aok_pkg::aok_state_t s_d;

   function automatic logic [5:0] rise(input logic [5:0] now, input logic [5:0] prev);
      rise = now & ~prev;
   endfunction : rise

   function automatic logic hit(input logic [31:0] a, input logic [7:0] base, input int i);
      hit = (a == {24'h00_0000, base} + 32'(i * 4));
   endfunction : hit

   logic [5:0]               trip_now;
   logic [5:0]               rel_now;
   logic [7:0]               var_alarm;
   aok_pkg::aok_keys_t       keys;
   logic [5:0]               disp_btn;
   logic [3:0]               last_in;
   logic [31:0]              rd_val;

   // -----------------------------------------------------------------
   // Alarm comparators
   // -----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `AOK_N_ALARM; g++) begin : g_alm
         aok_pkg::aok_acfg_t c;
         logic [15:0]        v;
         logic               ok;
         assign c  = aok_pkg::aok_acfg_t'(s_q.acfg[g]);
         assign v  = s_q.val[c.src];
         assign ok = s_q.ctrl[`AOK_CTRL_ANYST_BIT] | var_good[c.src];
         assign trip_now[g] = ok & ((c.en_lo & ($signed(v) < $signed(s_q.lo[g]))) |
                                    (c.en_hi & ($signed(v) > $signed(s_q.hi[g]))));
         assign rel_now[g]  = ~ok |
            ((~c.en_lo | ($signed(v) >= $signed(s_q.lo[g]) +
                          $signed(c.en_hys ? s_q.hys[g] : 16'h0000))) &
             (~c.en_hi | ($signed(v) <= $signed(s_q.hi[g]) -
                          $signed(c.en_hys ? s_q.hys[g] : 16'h0000))));
         assign alarm_contact[g] = s_q.ctrl[`AOK_CTRL_VALID_BIT] & s_q.pwr2 &
                                   (s_q.alarm[g] ^ c.nc);
      end
   endgenerate

   always_comb begin
      var_alarm = 8'h00;
      for (int i = 0; i < `AOK_N_ALARM; i++) begin
         if (s_q.alarm[i]) begin
            var_alarm[s_q.acfg[i][6:4]] = 1'b1;
         end
      end
   end

   assign var_invert     = ~var_good ^ (var_alarm & {8{s_q.blink}});
   assign var_bad        = ~var_good;
   assign status_text_on = s_q.ctrl[`AOK_CTRL_STXT_BIT] &
                           ((s_q.screen == 3'h0) | (s_q.screen == 3'h3));
   assign screen_index   = s_q.screen;
   assign menu_mode      = s_q.mode;
   assign irq            = |(s_q.int_stat & s_q.int_en);
   assign reg_rdata      = s_q.rdata;

   assign keys    = aok_pkg::aok_keys_t'(s_q.ctrl[`AOK_CTRL_KEYS_LSB +: 2]);
   assign last_in = s_q.ctrl[`AOK_CTRL_LAST_LSB +: 4];

   always_comb begin
      case (keys)
         aok_pkg::AOK_KEYS_INT:  disp_btn = s_q.int2;
         aok_pkg::AOK_KEYS_EXT:  disp_btn = {s_q.sync2[5:2], 2'b00};
         aok_pkg::AOK_KEYS_BOTH: disp_btn = s_q.int2 | {s_q.sync2[5:2], 2'b00};
         aok_pkg::AOK_KEYS_PORT: disp_btn = s_q.int2;
         default:                disp_btn = 6'h00;
      endcase
   end

   always_comb begin
      case (keys)
         aok_pkg::AOK_KEYS_INT:  key_status = s_q.int2;
         aok_pkg::AOK_KEYS_EXT:  key_status = s_q.sync2;
         aok_pkg::AOK_KEYS_BOTH: key_status = s_q.int2 | s_q.sync2;
         aok_pkg::AOK_KEYS_PORT: key_status = s_q.sync2;
         default:                key_status = 6'h00;
      endcase
      if (keys != aok_pkg::AOK_KEYS_PORT && s_q.mode == aok_pkg::AOK_MODE_CONF) begin
         key_status = 6'h00;
      end
      discrete_input_block = (keys == aok_pkg::AOK_KEYS_PORT) ? s_q.sync2 : 6'h00;
   end

   // -----------------------------------------------------------------
   // Read mux
   // -----------------------------------------------------------------
   always_comb begin
      rd_val = 32'h0000_0000;
      if (reg_addr == {24'h00_0000, `AOK_OFS_CTRL})     rd_val = s_q.ctrl;
      if (reg_addr == {24'h00_0000, `AOK_OFS_STATUS})
         rd_val = {8'h00, var_alarm, 2'b00, s_q.alarm, 2'b00, s_q.mode, 1'b0, s_q.screen};
      if (reg_addr == {24'h00_0000, `AOK_OFS_INT_STAT}) rd_val = {26'h0, s_q.int_stat};
      if (reg_addr == {24'h00_0000, `AOK_OFS_INT_EN})   rd_val = {26'h0, s_q.int_en};
      if (reg_addr == {24'h00_0000, `AOK_OFS_CODE})     rd_val = s_q.code;
      if (reg_addr == {24'h00_0000, `AOK_OFS_CODE_IN})  rd_val = s_q.code_in;
      for (int i = 0; i < `AOK_N_VAR; i++) begin
         if (hit(reg_addr, `AOK_OFS_VAL_BASE, i)) rd_val = {16'h0000, s_q.val[i]};
      end
      for (int i = 0; i < `AOK_N_ALARM; i++) begin
         if (hit(reg_addr, `AOK_OFS_ACFG_BASE, i)) rd_val = {25'h0, s_q.acfg[i]};
         if (hit(reg_addr, `AOK_OFS_ALO_BASE, i))  rd_val = {16'h0000, s_q.lo[i]};
         if (hit(reg_addr, `AOK_OFS_AHI_BASE, i))  rd_val = {16'h0000, s_q.hi[i]};
         if (hit(reg_addr, `AOK_OFS_AHYS_BASE, i)) rd_val = {16'h0000, s_q.hys[i]};
      end
   end

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      logic [5:0] pr;
      logic [5:0] ev;
      pr  = 6'h00;
      ev  = 6'h00;
      s_d = s_q;
      // Button and bus power pins pass two flops before any logic reads them.
      // Bus power has its own chain so that a switch input cannot open the contacts.
      s_d.sync1    = ext_btn;
      s_d.pwr1     = bus_power;
      s_d.pwr2     = s_q.pwr1;
      s_d.sync2    = s_q.sync1;
      s_d.int1     = panel_btn;
      s_d.int2     = s_q.int1;
      s_d.int_prev = disp_btn;
      s_d.ext_prev = s_q.sync2;
      s_d.rdata    = reg_rd ? rd_val : 32'h0000_0000;

      if (s_q.blink_cnt >= 32'(`AOK_BLINK_CYC - 1)) begin
         s_d.blink_cnt = 32'h0000_0000;
         s_d.blink     = ~s_q.blink;
      end else begin
         s_d.blink_cnt = s_q.blink_cnt + 32'h0000_0001;
      end

      for (int i = 0; i < `AOK_N_ALARM; i++) begin
         if (!s_q.alarm[i] && trip_now[i]) begin
            s_d.alarm[i] = 1'b1;
            ev[i]        = 1'b1;
         end else if (s_q.alarm[i] && rel_now[i]) begin
            s_d.alarm[i] = 1'b0;
         end
      end

      pr = rise(disp_btn, s_q.int_prev);
      case (aok_pkg::aok_mode_t'(s_q.mode))
         aok_pkg::AOK_MODE_OPER: begin
            if (disp_btn[5] && disp_btn[4] && (pr[5] || pr[4])) begin
               s_d.mode = aok_pkg::AOK_MODE_CONF;
            end else if (disp_btn[5] && disp_btn[2] && (pr[5] || pr[2])) begin
               s_d.mode  = (s_q.code == `AOK_CODE_RST) ? aok_pkg::AOK_MODE_QUICK
                                                      : aok_pkg::AOK_MODE_CODE;
            end else if (pr[2]) begin
               s_d.screen = (32'(s_q.screen) + 32'd2 > 32'(last_in)) ? 3'h0
                                                                  : s_q.screen + 3'h1;
            end else if (pr[3]) begin
               s_d.screen = (s_q.screen == 3'h0) ? 3'(last_in - 4'h1) : s_q.screen - 3'h1;
            end
            if (32'(s_q.screen) + 32'd1 > 32'(last_in)) s_d.screen = 3'h0;
         end
         aok_pkg::AOK_MODE_CODE: begin
            if (pr[4]) begin
               s_d.mode = (s_q.code_in == s_q.code) ? aok_pkg::AOK_MODE_QUICK
                                                    : aok_pkg::AOK_MODE_OPER;
            end
         end
         aok_pkg::AOK_MODE_CONF: begin
            // configuration menu left only by menu_exit, in every key mode
            if (menu_exit) s_d.mode = aok_pkg::AOK_MODE_OPER;
         end
         aok_pkg::AOK_MODE_QUICK: begin
            if (pr[4] || menu_exit) s_d.mode = aok_pkg::AOK_MODE_OPER;
         end
         default: s_d.mode = aok_pkg::AOK_MODE_OPER;
      endcase
      // panel keeps config chord in external mode
      if (keys == aok_pkg::AOK_KEYS_EXT && s_q.mode == aok_pkg::AOK_MODE_OPER &&
          s_q.int2[5] && s_q.int2[4]) begin
         s_d.mode = aok_pkg::AOK_MODE_CONF;
      end

      if (reg_wr) begin
         if (reg_addr == {24'h00_0000, `AOK_OFS_CTRL})    s_d.ctrl     = reg_wdata;
         if (reg_addr == {24'h00_0000, `AOK_OFS_INT_CLR})
            s_d.int_stat = s_q.int_stat & ~reg_wdata[5:0];
         if (reg_addr == {24'h00_0000, `AOK_OFS_INT_EN})  s_d.int_en   = reg_wdata[5:0];
         if (reg_addr == {24'h00_0000, `AOK_OFS_CODE})    s_d.code     = reg_wdata;
         if (reg_addr == {24'h00_0000, `AOK_OFS_CODE_IN}) s_d.code_in  = reg_wdata;
         for (int i = 0; i < `AOK_N_VAR; i++) begin
            if (hit(reg_addr, `AOK_OFS_VAL_BASE, i)) s_d.val[i] = reg_wdata[15:0];
         end
         for (int i = 0; i < `AOK_N_ALARM; i++) begin
            if (hit(reg_addr, `AOK_OFS_ACFG_BASE, i)) s_d.acfg[i] = reg_wdata[6:0];
            if (hit(reg_addr, `AOK_OFS_ALO_BASE, i))  s_d.lo[i]   = reg_wdata[15:0];
            if (hit(reg_addr, `AOK_OFS_AHI_BASE, i))  s_d.hi[i]   = reg_wdata[15:0];
            if (hit(reg_addr, `AOK_OFS_AHYS_BASE, i)) s_d.hys[i]  = reg_wdata[15:0];
         end
      end
      // A new trip wins over a clear in the same cycle.
      s_d.int_stat = s_d.int_stat | ev;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_q      <= '0;
         s_q.ctrl <= `AOK_CTRL_RST;
         s_q.code <= `AOK_CODE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   // open until valid
   contact_open_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !s_q.ctrl[`AOK_CTRL_VALID_BIT] |-> alarm_contact == 6'h00)
      else $error("contact closed before configuration valid");
   power_open_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !s_q.pwr2 |-> alarm_contact == 6'h00)
      else $error("contact closed without bus power");
   key_mute_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (s_q.mode == aok_pkg::AOK_MODE_CONF && keys != aok_pkg::AOK_KEYS_PORT)
      |-> key_status == 6'h00)
      else $error("key status reported inside configuration menu");
   port_di_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      keys == aok_pkg::AOK_KEYS_PORT |-> discrete_input_block == $past(s_q.sync1))
      else $error("discrete inputs do not follow external switches");
   alarm_trip_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!s_q.alarm[0] && trip_now[0]) |=> s_q.alarm[0])
      else $error("alarm did not trip");
   good_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!s_q.ctrl[`AOK_CTRL_ANYST_BIT] && !var_good[s_q.acfg[0][6:4]]) |-> !trip_now[0])
      else $error("alarm tripped on bad data");
   blink_var_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      var_alarm[0] && var_good[0] |-> var_invert[0] == s_q.blink)
      else $error("alarmed variable not blinking");
   bad_inv_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !var_alarm[1] && !var_good[1] |-> var_invert[1])
      else $error("bad variable not inverted");
   polarity_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (s_q.ctrl[`AOK_CTRL_VALID_BIT] && s_q.pwr2 && !s_q.alarm[1])
      |-> alarm_contact[1] == s_q.acfg[1][3])
      else $error("inactive contact level wrong");
   stat_text_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_q.screen == 3'h1 |-> !status_text_on)
      else $error("status text on wrong screen");
endmodule : aok_core
`default_nettype wire

// ### aok_far.sv
`default_nettype none
// ----------------------------------------------------------------------
// Far side: host status bits, bus power and operator buttons
// ----------------------------------------------------------------------
module aok_far #(
   parameter bit EXT_FITTED = 1'b1
) (
   input  wire logic       clk_sys,
   output logic      [5:0] panel_btn,
   output logic      [5:0] ext_btn,
   output logic      [7:0] var_good,
   output logic            bus_power,
   output logic            menu_exit
);
   timeunit 1ns;
   timeprecision 1ps;
   // Spare input 0 models a closed plant contact at rest.
   localparam logic [5:0] EXT_REST = 6'h01;
   initial begin
      panel_btn = 6'h00;
      ext_btn   = EXT_REST;
      var_good  = 8'hff;
      bus_power = 1'b1;
      menu_exit = 1'b0;
   end
   // Presses are held well past the two-flop synchroniser.
   task automatic press(input logic ext, input logic [5:0] pat);
      @(posedge clk_sys);
      if (!ext) begin
         panel_btn <= pat;
      end else if (EXT_FITTED) begin
         ext_btn <= pat;
      end
      repeat (6) @(posedge clk_sys);
      panel_btn <= 6'h00;
      ext_btn   <= EXT_REST;
      repeat (6) @(posedge clk_sys);
   endtask : press
   task automatic hold_ext(input logic [5:0] pat);
      @(posedge clk_sys);
      ext_btn <= pat;
   endtask : hold_ext
   task automatic power(input logic p);
      @(posedge clk_sys);
      bus_power <= p;
   endtask : power
   task automatic set_good(input logic [7:0] g);
      @(posedge clk_sys);
      var_good <= g;
   endtask : set_good
   task automatic leave_menu();
      @(posedge clk_sys);
      menu_exit <= 1'b1;
      @(posedge clk_sys);
      menu_exit <= 1'b0;
   endtask : leave_menu
endmodule : aok_far
`default_nettype wire

// ### aok_pkg.sv
`default_nettype none
package aok_pkg;
   typedef enum logic [1:0] {
      AOK_KEYS_INT  = 2'b00,
      AOK_KEYS_EXT  = 2'b01,
      AOK_KEYS_BOTH = 2'b10,
      AOK_KEYS_PORT = 2'b11
   } aok_keys_t;
   typedef enum logic [1:0] {
      AOK_MODE_OPER  = 2'b00,
      AOK_MODE_CODE  = 2'b01,
      AOK_MODE_CONF  = 2'b10,
      AOK_MODE_QUICK = 2'b11
   } aok_mode_t;
   typedef struct packed {
      logic [2:0] src;
      logic       nc;
      logic       en_lo;
      logic       en_hi;
      logic       en_hys;
   } aok_acfg_t;
   // Button set: program, enter, down, up, spare a, spare b.
   typedef struct packed {
      logic       prog;
      logic       enter;
      logic       down;
      logic       up;
      logic [1:0] spare;
   } aok_btn_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } aok_bus_t;
   typedef struct packed {
      logic [31:0]             ctrl;
      logic [31:0]             code;
      logic [31:0]             code_in;
      logic [5:0]              int_stat;
      logic [5:0]              int_en;
      logic [7:0][15:0]        val;
      logic [5:0][6:0]         acfg;
      logic [5:0][15:0]        lo;
      logic [5:0][15:0]        hi;
      logic [5:0][15:0]        hys;
      logic [5:0]              alarm;
      logic [5:0]              sync1;
      logic [5:0]              sync2;
      logic                    pwr1;
      logic                    pwr2;
      logic [5:0]              ext_prev;
      logic [5:0]              int1;
      logic [5:0]              int2;
      logic [5:0]              int_prev;
      logic [1:0]              mode;
      logic                    quick;
      logic [2:0]              screen;
      logic [31:0]             blink_cnt;
      logic                    blink;
      logic [31:0]             rdata;
   } aok_state_t;
endpackage : aok_pkg
`default_nettype wire

// ### tb.sv
`include "aok_cfg.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys;
   logic        rst_n;
   logic [31:0] reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        bus_power;
   logic [7:0]  var_good;
   logic [5:0]  panel_btn;
   logic [5:0]  ext_btn;
   logic        menu_exit;
   logic [5:0]  alarm_contact;
   logic [7:0]  var_invert;
   logic [7:0]  var_bad;
   logic        status_text_on;
   logic [2:0]  screen_index;
   logic [5:0]  key_status;
   logic [5:0]  discrete_input_block;
   logic [1:0]  menu_mode;
   logic        irq;
   logic [31:0] rd_val;
   int          err_count;
   int          comparisons;
   int          cycles;
   aok_core aok_core_inst (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .bus_power(bus_power), .var_good(var_good), .panel_btn(panel_btn),
      .ext_btn(ext_btn), .menu_exit(menu_exit), .alarm_contact(alarm_contact),
      .var_invert(var_invert), .var_bad(var_bad), .status_text_on(status_text_on),
      .screen_index(screen_index), .key_status(key_status),
      .discrete_input_block(discrete_input_block), .menu_mode(menu_mode), .irq(irq));
   aok_far aok_far_inst (.clk_sys(clk_sys), .panel_btn(panel_btn), .ext_btn(ext_btn),
      .var_good(var_good), .bus_power(bus_power), .menu_exit(menu_exit));
   // ----------------------------------------------------------------------
   // Clock, reset and hang guard
   // ----------------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         conclude();
      end
   end
   // ----------------------------------------------------------------------
   // Bus tasks and checks
   // ----------------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= {24'h0, a};
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_addr <= {24'h0, a};
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask : rd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
         err_count++;
      end
   endtask : chk
   // Level outputs pass a synchroniser and a register stage, so allow eight cycles.
   task automatic settle();
      repeat (8) @(posedge clk_sys);
   endtask : settle
   task automatic alarm(input int i, input logic [6:0] c, input logic [15:0] lo,
                        input logic [15:0] hi, input logic [15:0] hys);
      wr(`AOK_OFS_ACFG_BASE + 8'(4 * i), {25'h0, c});
      wr(`AOK_OFS_ALO_BASE + 8'(4 * i), {16'h0, lo});
      wr(`AOK_OFS_AHI_BASE + 8'(4 * i), {16'h0, hi});
      wr(`AOK_OFS_AHYS_BASE + 8'(4 * i), {16'h0, hys});
   endtask : alarm
   task automatic val(input int i, input logic [15:0] v);
      wr(`AOK_OFS_VAL_BASE + 8'(4 * i), {16'h0, v});
      settle();
   endtask : val
   function automatic logic [31:0] ctl(input logic vld, input logic anyst,
                                       input logic [1:0] keys, input logic [3:0] last);
      return {20'h0, last, 2'h0, keys, 1'b0, 1'b1, anyst, vld};
   endfunction : ctl
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   // ----------------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      reg_addr = 32'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      err_count = 0;
      comparisons = 0;
      cycles = 0;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(`AOK_OFS_CTRL);       chk(rd_val, 32'h0000_0724, "ctrl reset");
      rd(`AOK_OFS_CODE);       chk(rd_val, 32'h3030_3030, "code reset");
      rd(8'hfc);               chk(rd_val, 32'h0, "unmapped read");
      chk({26'h0, alarm_contact}, 32'h0, "contacts after reset");
      chk({30'h0, menu_mode, irq, status_text_on}, 32'h1, "reset outputs");
      wr(`AOK_OFS_CTRL, 32'h0000_0720);
      settle();
      chk({31'h0, status_text_on}, 32'h0, "status text off");
      $display("test reset done");
      alarm(0, {3'd2, 4'b0010}, 16'h0, 16'h0032, 16'h0);
      alarm(1, {3'd3, 4'b1100}, 16'h000a, 16'h0, 16'h0);
      alarm(2, {3'd4, 4'b0011}, 16'h0, 16'h0032, 16'h000a);
      alarm(3, {3'd5, 4'b1000}, 16'h0, 16'h0, 16'h0);
      wr(`AOK_OFS_VAL_BASE + 8'h08, 32'h64);
      wr(`AOK_OFS_VAL_BASE + 8'h0c, 32'h05);
      val(4, 16'h003c);
      chk({26'h0, alarm_contact}, 32'h0, "contacts before valid");
      wr(`AOK_OFS_CTRL, ctl(1'b1, 1'b0, 2'd2, 4'd7));
      settle();
      chk({26'h0, alarm_contact}, 32'h0d, "trip and polarity");
      val(4, 16'h002d);
      chk({26'h0, alarm_contact}, 32'h0d, "inside hysteresis");
      val(4, 16'h0027);
      chk({26'h0, alarm_contact}, 32'h09, "hysteresis release");
      val(3, 16'h0014);
      chk({26'h0, alarm_contact}, 32'h0b, "low released");
      aok_far_inst.set_good(8'hfb);
      settle();
      chk({26'h0, alarm_contact}, 32'h0a, "bad data blocks trip");
      chk({31'h0, var_bad[2]}, 32'h1, "bad flag");
      wr(`AOK_OFS_CTRL, ctl(1'b1, 1'b1, 2'd2, 4'd7));
      settle();
      chk({26'h0, alarm_contact}, 32'h0b, "any status trips");
      chk({31'h0, var_invert[2]}, 32'h1, "bad shown inverted");
      aok_far_inst.power(1'b0);
      settle();
      chk({26'h0, alarm_contact}, 32'h0, "unpowered open");
      aok_far_inst.power(1'b1);
      aok_far_inst.set_good(8'hff);
      $display("test alarms done");
      val(2, 16'h0000);
      wr(`AOK_OFS_INT_CLR, 32'h3f);
      rd(`AOK_OFS_INT_STAT);   chk(rd_val & 32'h1, 32'h0, "status cleared");
      wr(`AOK_OFS_INT_EN, 32'h1);
      settle();
      chk({31'h0, irq}, 32'h0, "irq idle");
      val(2, 16'h0064);
      rd(`AOK_OFS_INT_STAT);   chk(rd_val & 32'h1, 32'h1, "status set");
      chk({31'h0, irq}, 32'h1, "irq raised");
      wr(`AOK_OFS_INT_EN, 32'h0);
      settle();
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr(`AOK_OFS_INT_CLR, 32'h3f);
      wr(`AOK_OFS_CTRL, ctl(1'b0, 1'b1, 2'd2, 4'd7));
      settle();
      chk({26'h0, alarm_contact}, 32'h0, "unconfigured open");
      $display("test interrupt done");
      aok_far_inst.press(1'b0, 6'h30);
      chk({30'h0, menu_mode}, 32'h2, "both panel config");
      aok_far_inst.hold_ext(6'h05);
      settle();
      chk({26'h0, key_status}, 32'h0, "muted in config");
      aok_far_inst.hold_ext(6'h01);
      aok_far_inst.leave_menu();
      settle();
      wr(`AOK_OFS_CTRL, ctl(1'b0, 1'b0, 2'd1, 4'd7));
      aok_far_inst.press(1'b0, 6'h24);
      chk({30'h0, menu_mode}, 32'h0, "ext ignores panel quick");
      aok_far_inst.press(1'b0, 6'h30);
      chk({30'h0, menu_mode}, 32'h2, "ext panel config");
      aok_far_inst.leave_menu();
      aok_far_inst.press(1'b1, 6'h24);
      chk({30'h0, menu_mode}, 32'h3, "ext quick");
      aok_far_inst.leave_menu();
      wr(`AOK_OFS_CTRL, ctl(1'b0, 1'b0, 2'd0, 4'd7));
      aok_far_inst.press(1'b1, 6'h30);
      chk({30'h0, menu_mode}, 32'h0, "int ignores ext");
      wr(`AOK_OFS_CTRL, ctl(1'b0, 1'b0, 2'd3, 4'd7));
      aok_far_inst.press(1'b0, 6'h30);
      aok_far_inst.hold_ext(6'h15);
      settle();
      chk({26'h0, discrete_input_block}, 32'h15, "discrete inputs");
      chk({26'h0, key_status}, 32'h15, "port reports in config");
      aok_far_inst.hold_ext(6'h01);
      aok_far_inst.leave_menu();
      $display("test keys done");
      wr(`AOK_OFS_CTRL, ctl(1'b0, 1'b0, 2'd2, 4'd2));
      wr(`AOK_OFS_CODE, 32'h4162_3132);
      aok_far_inst.press(1'b0, 6'h24);
      chk({30'h0, menu_mode}, 32'h1, "code prompt");
      wr(`AOK_OFS_CODE_IN, 32'h6162_3132);
      aok_far_inst.press(1'b0, 6'h10);
      chk({30'h0, menu_mode}, 32'h0, "case mismatch refused");
      aok_far_inst.press(1'b0, 6'h24);
      wr(`AOK_OFS_CODE_IN, 32'h4162_3132);
      aok_far_inst.press(1'b0, 6'h10);
      chk({30'h0, menu_mode}, 32'h3, "code accepted");
      aok_far_inst.leave_menu();
      settle();
      for (int n = 0; n < 5; n++) begin
         aok_far_inst.press(1'b0, 6'h04);
         chk({29'h0, screen_index}, 32'((n + 1) % 2), "scroll limit");
      end
      $display("test code and scroll done");
      conclude();
   end
endmodule : tb
`default_nettype wire
